// ---- hw/ocr_pkg.sv ----
// constants, field layout and types of the oscillator control register bank
`default_nettype none

package ocr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets (7-bit serial address)
   localparam logic [6:0] OFS_PULL_LOW     = 7'h00;
   localparam logic [6:0] OFS_ENA_PULL_HI  = 7'h01;
   localparam logic [6:0] OFS_PULL_RANGE   = 7'h02;
   localparam logic [6:0] OFS_FB_INT_FRAC  = 7'h03;
   localparam logic [6:0] OFS_FB_FRAC_LOW  = 7'h04;
   localparam logic [6:0] OFS_FWD_DIV_DRV  = 7'h05;
   localparam logic [6:0] OFS_DRV_DIV_DRV  = 7'h06;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int POS_OE_BIT     = 10;
   localparam int POS_PULL_HI_MSB = 9;
   localparam int POS_FB_INT_LSB = 11;
   localparam int POS_FWD_LSB    = 3;
   localparam int POS_DRV_DIV    = 3;
   localparam int PULL_HI_W      = 10;
   localparam int PULL_W         = 26;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [15:0] RST_PULL_LOW = 16'h0000;
   localparam logic [9:0]  RST_PULL_HI  = 10'h000;
   localparam logic        RST_OE_BIT   = 1'b0;
   localparam logic [3:0]  RST_RANGE    = 4'h0;
   localparam logic [15:0] RST_FB_HI    = 16'h0000;
   localparam logic [15:0] RST_FB_LOW   = 16'h0000;
   localparam logic [15:0] RST_FWD_DRV  = 16'h0000;
   localparam logic [3:0]  RST_DRV_DIV  = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // serial frame counts: 8 command bits then 16-bit data words
   localparam logic [3:0] CMD_LAST_BIT  = 4'h7;
   localparam logic [3:0] DATA_LAST_BIT = 4'hf;
   localparam int         SYNC_STAGES   = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_DATA
   } ocr_state_t;

   typedef struct packed {
      logic [4:0]  fb_int;
      logic [10:0] fb_frac_hi;
      logic [15:0] fb_frac_low;
      logic [12:0] fwd_div;
      logic [2:0]  fwd_drv;
      logic        drv_div;
      logic [2:0]  drv_ctrl;
   } ocr_cfg_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } ocr_spi_in_t;

endpackage : ocr_pkg

`default_nettype wire

// ---- hw/ocr_sync.sv ----
// three-stage input synchroniser with agreement filter, one lane per bit
`default_nettype none

module ocr_sync #(
   parameter int               WIDTH     = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // asynchronous inputs and filtered levels
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] level_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // per-bit chain: stage 1 feeds only stage 2; level moves once 2 and 3 agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_lane
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               s1_reg       <= RESET_VAL[i];
               s2_reg       <= RESET_VAL[i];
               s3_reg       <= RESET_VAL[i];
               level_out[i] <= RESET_VAL[i];
            end else begin
               s1_reg <= async_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  level_out[i] <= s3_reg;
               end
            end
         end
      end
   endgenerate

endmodule : ocr_sync

`default_nettype wire

// ---- hw/ocr_top.sv ----
// oscillator control register bank behind a sampled serial port
`default_nettype none

module ocr_top #(
   parameter logic       OE_FROM_PIN   = 1'b0,
   parameter logic [3:0] FACTORY_RANGE = ocr_pkg::RST_RANGE
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // serial port pins
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              mosi,
   output var  logic              miso,
   // hardware enable pin
   input  wire logic              oe_pin,
   // oscillator controls
   output var  logic              out_enable,
   output var  logic signed [25:0] pull_word,
   output var  logic              pull_update,
   output var  logic              pull_above,
   output var  logic              pull_below,
   output var  logic [3:0]        pull_range,
   output var  ocr_pkg::ocr_cfg_t cfg
);

   ////////////////////////////////////////////////////////////////////////////////
   // input sampling
   ocr_pkg::ocr_spi_in_t spi_f;
   logic                 oe_pin_f;
   logic                 sclk_prev_reg;

   ocr_sync #(
      .WIDTH     (4),
      .RESET_VAL (4'h2)
   ) u_sync (
      .clk       (clk),
      .arst_n    (arst_n),
      .async_in  ({oe_pin, sclk, cs_n, mosi}),
      .level_out ({oe_pin_f, spi_f})
   );

   wire sclk_rise = spi_f.sclk & ~sclk_prev_reg;
   wire sclk_fall = ~spi_f.sclk & sclk_prev_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // frame state
   ocr_pkg::ocr_state_t state_reg;
   ocr_pkg::ocr_state_t state_next;
   logic [3:0]          bit_cnt_reg;
   logic [15:0]         rx_reg;
   logic [15:0]         tx_reg;
   logic [6:0]          addr_reg;
   logic                rd_mode_reg;

   wire [15:0] rx_next   = {rx_reg[14:0], spi_f.mosi};
   wire        cmd_done  = sclk_rise && (state_reg == ocr_pkg::ST_CMD)
                           && (bit_cnt_reg == ocr_pkg::CMD_LAST_BIT);
   wire        word_done = sclk_rise && (state_reg == ocr_pkg::ST_DATA)
                           && (bit_cnt_reg == ocr_pkg::DATA_LAST_BIT);
   wire [6:0]  addr_cur  = cmd_done ? rx_next[6:0] : addr_reg;
   wire [6:0]  addr_rd   = cmd_done ? rx_next[6:0] : 7'(addr_reg + 7'h01);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ocr_pkg::ST_IDLE: begin
            if (!spi_f.cs_n) begin
               state_next = ocr_pkg::ST_CMD;
            end
         end
         ocr_pkg::ST_CMD: begin
            if (cmd_done) begin
               state_next = ocr_pkg::ST_DATA;
            end
         end
         ocr_pkg::ST_DATA: begin
            state_next = ocr_pkg::ST_DATA;
         end
      endcase
      if (spi_f.cs_n) begin
         state_next = ocr_pkg::ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [15:0] pull_low_reg;
   logic [9:0]  pull_hi_reg;
   logic        oe_bit_reg;
   logic        commit_seen_reg;

   // write strobes: word complete in a write frame, decoded by address
   wire        wr_any   = word_done && !rd_mode_reg;
   wire [15:0] wdata    = rx_next;
   wire        wr_low   = wr_any && (addr_reg == ocr_pkg::OFS_PULL_LOW);
   wire        wr_high  = wr_any && (addr_reg == ocr_pkg::OFS_ENA_PULL_HI);
   wire        wr_range = wr_any && (addr_reg == ocr_pkg::OFS_PULL_RANGE);
   wire        wr_fb_hi = wr_any && (addr_reg == ocr_pkg::OFS_FB_INT_FRAC);
   wire        wr_fb_lo = wr_any && (addr_reg == ocr_pkg::OFS_FB_FRAC_LOW);
   wire        wr_fwd   = wr_any && (addr_reg == ocr_pkg::OFS_FWD_DIV_DRV);
   wire        wr_drv   = wr_any && (addr_reg == ocr_pkg::OFS_DRV_DIV_DRV);

   // committed word is the new high field over the stored low word
   wire [25:0] commit_word = {wdata[ocr_pkg::POS_PULL_HI_MSB:0], pull_low_reg};
   wire        commit_neg  = commit_word[ocr_pkg::PULL_W-1];
   wire        commit_pos  = !commit_neg && (commit_word != 26'h0000000);
   // enable bit is writable only when software owns the driver enable
   wire        oe_bit_next = OE_FROM_PIN ? 1'b0 : wdata[ocr_pkg::POS_OE_BIT];
   wire        oe_source   = OE_FROM_PIN ? oe_pin_f : oe_bit_reg;

   // read mux; unused upper bits and unmapped addresses read zero
   logic [15:0] rdata;
   assign rdata =
      (addr_rd == ocr_pkg::OFS_PULL_LOW)    ? pull_low_reg :
      (addr_rd == ocr_pkg::OFS_ENA_PULL_HI) ? {5'h00, oe_bit_reg, pull_hi_reg} :
      (addr_rd == ocr_pkg::OFS_PULL_RANGE)  ? {12'h000, pull_range} :
      (addr_rd == ocr_pkg::OFS_FB_INT_FRAC) ? {cfg.fb_int, cfg.fb_frac_hi} :
      (addr_rd == ocr_pkg::OFS_FB_FRAC_LOW) ? cfg.fb_frac_low :
      (addr_rd == ocr_pkg::OFS_FWD_DIV_DRV) ? {cfg.fwd_div, cfg.fwd_drv} :
      (addr_rd == ocr_pkg::OFS_DRV_DIV_DRV) ? {12'h000, cfg.drv_div, cfg.drv_ctrl} :
      16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // serial engine
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= ocr_pkg::ST_IDLE;
         sclk_prev_reg <= 1'b0;
         bit_cnt_reg   <= 4'h0;
         rx_reg        <= 16'h0000;
         addr_reg      <= 7'h00;
         rd_mode_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         sclk_prev_reg <= spi_f.sclk;
         if (state_next == ocr_pkg::ST_IDLE || cmd_done || word_done) begin
            bit_cnt_reg <= 4'h0;
         end else if (sclk_rise) begin
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            rx_reg      <= rx_next;
         end
         if (cmd_done) begin
            rd_mode_reg <= rx_next[7];
         end
         if (cmd_done || word_done) begin
            addr_reg <= word_done ? 7'(addr_reg + 7'h01) : addr_cur;
         end
      end
   end

   // read data loads at word boundaries and leaves msb first on falling edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_reg <= 16'h0000;
         miso   <= 1'b0;
      end else if (state_next == ocr_pkg::ST_IDLE) begin
         tx_reg <= 16'h0000;
         miso   <= 1'b0;
      end else if ((cmd_done && rx_next[7]) || (word_done && rd_mode_reg)) begin
         tx_reg <= rdata;
      end else if (sclk_fall && state_reg == ocr_pkg::ST_DATA && rd_mode_reg) begin
         miso   <= tx_reg[15];
         tx_reg <= {tx_reg[14:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frequency pull word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pull_low_reg    <= ocr_pkg::RST_PULL_LOW;
         pull_hi_reg     <= ocr_pkg::RST_PULL_HI;
         pull_word       <= 26'sh0000000;
         pull_update     <= 1'b0;
         pull_above      <= 1'b0;
         pull_below      <= 1'b0;
         commit_seen_reg <= 1'b0;
      end else begin
         pull_update <= wr_high;
         if (wr_low) begin
            pull_low_reg <= wdata;
         end
         if (wr_high) begin
            pull_hi_reg     <= wdata[ocr_pkg::POS_PULL_HI_MSB:0];
            pull_word       <= commit_word;
            pull_above      <= commit_pos;
            pull_below      <= commit_neg;
            commit_seen_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output enable, range and divider fields
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oe_bit_reg      <= ocr_pkg::RST_OE_BIT;
         out_enable      <= 1'b0;
         // range comes up at the factory choice
         pull_range      <= FACTORY_RANGE;
         cfg             <= '0;
      end else begin
         out_enable <= oe_source;
         if (wr_high) begin
            oe_bit_reg <= oe_bit_next;
         end
         if (wr_range) begin
            pull_range <= wdata[3:0];
         end
         if (wr_fb_hi) begin
            cfg.fb_int     <= wdata[15:ocr_pkg::POS_FB_INT_LSB];
            cfg.fb_frac_hi <= wdata[ocr_pkg::POS_FB_INT_LSB-1:0];
         end
         if (wr_fb_lo) begin
            cfg.fb_frac_low <= wdata;
         end
         if (wr_fwd) begin
            cfg.fwd_div <= wdata[15:ocr_pkg::POS_FWD_LSB];
            cfg.fwd_drv <= wdata[ocr_pkg::POS_FWD_LSB-1:0];
         end
         if (wr_drv) begin
            cfg.drv_div  <= wdata[ocr_pkg::POS_DRV_DIV];
            cfg.drv_ctrl <= wdata[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   a_low_no_commit: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_low && !wr_high) |=> $stable(pull_word) && !pull_update)
      else $error("low word write changed the pull word");

   a_high_commit: assert property (@(posedge clk) disable iff (!arst_n)
      wr_high |=> (pull_word == {$past(wdata[9:0]), $past(pull_low_reg)}) && pull_update)
      else $error("high word write did not commit the combined word");

   a_pull_reset_zero: assert property (@(posedge clk) disable iff (!arst_n)
      !commit_seen_reg |-> (pull_word == 26'sh0000000) && !pull_above && !pull_below)
      else $error("pull word not zero before first commit");

   a_pull_sign: assert property (@(posedge clk) disable iff (!arst_n)
      (pull_below == (pull_word < 0)) && (pull_above == (pull_word > 0)))
      else $error("pull direction flags disagree with signed word");

   a_oe_pin_lock: assert property (@(posedge clk) disable iff (!arst_n)
      OE_FROM_PIN |-> !oe_bit_reg)
      else $error("enable bit changed in pin mode");

   a_oe_soft_write: assert property (@(posedge clk) disable iff (!arst_n)
      (!OE_FROM_PIN && wr_high) |=> oe_bit_reg == $past(wdata[10]))
      else $error("enable bit did not take the written value");

   a_out_enable: assert property (@(posedge clk) disable iff (!arst_n)
      !OE_FROM_PIN |-> ##1 (out_enable == $past(oe_bit_reg)))
      else $error("driver enable does not follow the enable bit");

   a_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
      (addr_rd == ocr_pkg::OFS_PULL_RANGE || addr_rd == ocr_pkg::OFS_ENA_PULL_HI)
      |-> (rdata[15:11] == 5'h00) && (addr_rd != ocr_pkg::OFS_PULL_RANGE
          || rdata[15:4] == 12'h000))
      else $error("unused bits read non-zero");

   a_range_write: assert property (@(posedge clk) disable iff (!arst_n)
      wr_range |=> pull_range == $past(wdata[3:0]))
      else $error("pull range field not written");

   a_fb_fields: assert property (@(posedge clk) disable iff (!arst_n)
      wr_fb_hi |=> {cfg.fb_int, cfg.fb_frac_hi} == $past(wdata))
      else $error("divider integer and fraction high not written");

   a_frac_low: assert property (@(posedge clk) disable iff (!arst_n)
      wr_fb_lo ##1 (!wr_fb_lo) [*2] |-> cfg.fb_frac_low == $past(wdata, 2))
      else $error("divider fraction low word not held");

   a_pin_follow: assert property (@(posedge clk) disable iff (!arst_n)
      OE_FROM_PIN |=> out_enable == $past(oe_pin_f))
      else $error("driver enable does not follow the enable pin");

   a_read_load: assert property (@(posedge clk) disable iff (!arst_n)
      (word_done && rd_mode_reg && !spi_f.cs_n) |=> tx_reg == $past(rdata))
      else $error("read word not loaded at word boundary");

   a_unmapped_write: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_any && addr_reg > ocr_pkg::OFS_DRV_DIV_DRV) |=> $stable(pull_word)
      && $stable(cfg) && $stable(pull_range) && $stable(oe_bit_reg))
      else $error("write to unmapped offset changed a register");

   a_frame_abort: assert property (@(posedge clk) disable iff (!arst_n)
      spi_f.cs_n |=> (state_reg == ocr_pkg::ST_IDLE) && !miso)
      else $error("frame not ended by chip select");

   c_commit: cover property (@(posedge clk) disable iff (!arst_n)
      wr_low ##[1:200] wr_high);
   c_read_word: cover property (@(posedge clk) disable iff (!arst_n)
      word_done && rd_mode_reg);
   c_enable_on: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(out_enable));
   c_negative_pull: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(pull_below));
   c_cut_frame: cover property (@(posedge clk) disable iff (!arst_n)
      (state_reg == ocr_pkg::ST_DATA) && spi_f.cs_n && (bit_cnt_reg != 4'h0));

endmodule : ocr_top

`default_nettype wire

// ---- tb/ocr_host.sv ----
// serial host model that drives the register bank over spi mode 0 pins
`default_nettype none

module ocr_host (
   // clock
   input  wire logic clk,
   // serial pins
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] tx [8];
   logic [15:0] rx [8];

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end

   // half of an 80 ns serial period
   task automatic half();
      repeat (4) @(negedge clk);
   endtask : half

   ////////////////////////////////////////////////////////////////////////////////
   // one frame: command byte, then 16-bit words msb first
   task automatic frame(input logic [7:0] cmd, input int nbits);
      int w;
      @(negedge clk);
      cs_n = 1'b0;
      half();
      for (int i = 0; i < nbits; i++) begin
         w = (i - 8) / 16;
         // words leave in address order, so the low word goes before the high word
         mosi = (i < 8) ? cmd[7-i] : tx[w][15-(i-8)%16];
         half();
         sclk = 1'b1;
         half();
         if (i >= 8) begin
            rx[w][15-(i-8)%16] = miso;
         end
         sclk = 1'b0;
      end
      half();
      cs_n = 1'b1;
      // released data line must not keep its last value
      mosi = ~mosi;
      repeat (8) @(negedge clk);
   endtask : frame

endmodule : ocr_host

`default_nettype wire

// ---- tb/ocr_top_tb_top.sv ----
// self-checking bench of the oscillator control register bank
`default_nettype none

module ocr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic                     clk         = 1'b0;
   logic                     arst_n      = 1'b0;
   logic                     oe_pin      = 1'b0;
   logic                     sel         = 1'b0;
   logic                     sclk;
   logic                     cs_n;
   logic                     mosi;
   logic                     miso_sw;
   logic                     miso_pin;
   logic                     miso_bus;
   logic                     oe_sw;
   logic                     oe_hw;
   logic signed [25:0]       pw_sw;
   logic signed [25:0]       pw_hw;
   logic                     pu_sw;
   logic                     above;
   logic                     below;
   logic [3:0]               range_sw;
   ocr_pkg::ocr_cfg_t        cfg_sw;
   int                       err_total   = 0;
   int                       total_checks = 0;
   int                       cyc         = 0;
   int                       pu_cnt      = 0;
   int                       pu_exp      = 0;
   logic [31:0]              seed        = 32'h00cd;
   logic [15:0]              m [8];
   logic [25:0]              pw_exp;

   always #5 clk = ~clk;
   assign miso_bus = sel ? miso_pin : miso_sw;

   ocr_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_bus));

   ocr_top #(.OE_FROM_PIN(1'b0)) uut (
      .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_sw),
      .oe_pin(oe_pin), .out_enable(oe_sw), .pull_word(pw_sw), .pull_update(pu_sw),
      .pull_above(above), .pull_below(below), .pull_range(range_sw), .cfg(cfg_sw));

   ocr_top #(.OE_FROM_PIN(1'b1)) uut_pin (
      .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_pin),
      .oe_pin(oe_pin), .out_enable(oe_hw), .pull_word(pw_hw), .pull_update(),
      .pull_above(), .pull_below(), .pull_range(), .cfg());

   ////////////////////////////////////////////////////////////////////////////////
   // cycle ceiling and commit pulse counter
   always @(posedge clk) begin
      cyc++;
      if (pu_sw === 1'b1) begin
         pu_cnt++;
      end
      if (cyc == 60000) begin
         err_total++;
         conclude();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // readable bits of each offset
   function automatic logic [15:0] mask(input int a, input logic pin);
      case (a)
         0, 3, 4, 5: return 16'hffff;
         1:          return pin ? 16'h03ff : 16'h07ff;
         2, 6:       return 16'h000f;
         default:    return 16'h0000;
      endcase
   endfunction : mask

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_out

   ////////////////////////////////////////////////////////////////////////////////
   // register access through the host model, with the reference model updated
   task automatic wr(input int a, input int n);
      for (int k = 0; k < n; k++) begin
         if (a + k < 7) begin
            m[a+k] = host.tx[k] & mask(a + k, 1'b0);
         end
         if (a + k == 1) begin
            pw_exp = {m[1][9:0], m[0]};
            pu_exp++;
         end
      end
      host.frame({1'b0, a[6:0]}, 8 + 16 * n);
   endtask : wr

   task automatic rd(input int a, input int n, input logic pin);
      sel = pin;
      host.frame({1'b1, a[6:0]}, 8 + 16 * n);
      for (int k = 0; k < n; k++) begin
         chk_reg(host.rx[k], m[a+k] & mask(a + k, pin));
      end
   endtask : rd

   task automatic chk_outs();
      chk_out({38'h0, pw_sw}, {38'h0, pw_exp});
      chk_out({38'h0, pw_hw}, {38'h0, pw_exp});
      chk_out({62'h0, above, below}, {62'h0, |pw_exp & ~pw_exp[25], pw_exp[25]});
      chk_out({62'h0, oe_sw, oe_hw}, {62'h0, m[1][10], oe_pin});
      chk_out({60'h0, range_sw}, {60'h0, m[2][3:0]});
      chk_out({12'h0, cfg_sw}, {12'h0, m[3], m[4], m[5], m[6][3:0]});
      chk_out(64'(pu_cnt), 64'(pu_exp));
   endtask : chk_outs

   task automatic conclude();
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int a = 0; a < 8; a++) begin
         m[a] = 16'h0000;
      end
      pw_exp = 26'h0;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk_outs();
      rd(0, 8, 1'b0);
      host.tx[0] = 16'(rnd());
      wr(0, 1);
      chk_outs();
      // high word cut short after 12 bits must be dropped
      host.tx[0] = 16'h07ff;
      host.frame(8'h01, 20);
      chk_outs();
      for (int it = 0; it < 8; it++) begin
         oe_pin = 1'(rnd());
         for (int k = 0; k < 8; k++) begin
            host.tx[k] = 16'(rnd());
         end
         if (it == 0) begin
            host.tx[0] = 16'h0000;
            host.tx[1] = 16'h0200;
         end
         if (it == 1) begin
            host.tx[0] = 16'hffff;
            host.tx[1] = 16'h05ff;
         end
         wr(0, 8);
         chk_outs();
         rd(0, 8, 1'b0);
         rd(0, 8, 1'b1);
         host.tx[0] = 16'(rnd());
         wr(1, 1);
         chk_outs();
      end
      conclude();
   end

endmodule : ocr_top_tb_top

`default_nettype wire
